// >>> hdl/emapm_pin_mux.sv
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/1ps
// How it works
// - with an 8-bit memory, byte address bits 22..2 go to pins 20..0.
// - with an 8-bit memory, byte address bits 1..0 go to the byte pins.
// - with a 16-bit memory, address bits 21..1 go to pins 20..0.
// - with a 16-bit memory, address bit 0 goes to byte pin 1.
// - pins 15..20 are shared with i/o lines 21..26, one mode bit each.
// - in nand mode pin 12 also carries the command latch enable.
// - in nand mode pin 11 also carries the address latch enable.
// - software enables or disables the pulldown on each shared pin.
// - pins 14 and below belong to the memory interface only.
module emapm_pin_mux (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  // memory controller side
  input  wire logic [22:0] i_mem_addr,
  input  wire logic        i_addr_oe,
  input  wire logic        i_bus16,
  input  wire logic        i_nand_mode,
  input  wire logic        i_nand_cle,
  input  wire logic        i_nand_ale,
  // general i/o logic side, bit k is line 21+k
  input  wire logic [5:0]  i_general_io_line_out,
  input  wire logic [5:0]  i_general_io_line_dir,
  output logic [5:0]       o_general_io_line_in,
  // register port
  input  wire logic [3:0]  i_reg_addr,
  input  wire logic [15:0] i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic [15:0]      o_reg_rdata,
  // pads
  input  wire logic [20:0] i_ext_addr_pins,
  output logic [20:0]      o_ext_addr_pins,
  output logic [20:0]      o_ext_addr_pins_oe_n,
  output logic [1:0]       o_ext_byte_sel_addr,
  output logic [5:0]       o_internal_pulldown_en
);

  logic [5:0]  pin_share_select_reg_r;
  logic [5:0]  pull_inhibit_reg_r;
  logic [15:0] rdata_r;
  logic [14:0] dedic_out_r;
  logic [14:0] dedic_oe_n_r;
  logic [1:0]  byte_sel_r;
  logic [5:0]  shared_out;
  logic [5:0]  shared_oe_n;

  // register decode
  wire logic wr_share = i_reg_wr && (i_reg_addr == emapm_pkg::OFS_SHARE_SEL);
  wire logic wr_pull  = i_reg_wr && (i_reg_addr == emapm_pkg::OFS_PULL_INH);
  wire logic rd_share = i_reg_rd && (i_reg_addr == emapm_pkg::OFS_SHARE_SEL);
  wire logic rd_pull  = i_reg_rd && (i_reg_addr == emapm_pkg::OFS_PULL_INH);
  wire logic rd_pins  = i_reg_rd && (i_reg_addr == emapm_pkg::OFS_PIN_STAT);
  wire logic rd_mode  = i_reg_rd && (i_reg_addr == emapm_pkg::OFS_MODE_STAT);

  wire logic [5:0] share_nxt = wr_share ?
    i_reg_wdata[emapm_pkg::SHARE_SEL_LSB +: 6] : pin_share_select_reg_r;
  wire logic [5:0] pull_nxt = wr_pull ?
    i_reg_wdata[emapm_pkg::PULL_INH_LSB +: 6] : pull_inhibit_reg_r;

  // mode status shows the controller straps the mux is acting on
  wire logic [2:0] mode_stat = {i_addr_oe, i_nand_mode, i_bus16};

  // read mux; unmapped offsets read as zero
  wire logic [15:0] rdata_nxt =
    rd_share ? {10'h000, pin_share_select_reg_r} :
    rd_pull  ? {10'h000, pull_inhibit_reg_r} :
    rd_pins  ? {10'h000, i_ext_addr_pins[20:15]} :
    rd_mode  ? {13'h0, mode_stat} : 16'h0000;

  // control registers; a strobe takes effect on the next edge
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      pin_share_select_reg_r <= emapm_pkg::RST_SHARE_SEL;
      pull_inhibit_reg_r     <= emapm_pkg::RST_PULL_INH;
      rdata_r                <= 16'h0000;
    end else begin
      pin_share_select_reg_r <= share_nxt;
      pull_inhibit_reg_r     <= pull_nxt;
      rdata_r                <= rdata_nxt;
    end
  end

  assign o_reg_rdata = rdata_r;

  // a set inhibit bit turns the pulldown off
  assign o_internal_pulldown_en = ~pull_inhibit_reg_r;

  // word address for 16-bit parts, byte address for 8-bit parts
  wire logic [20:0] map_addr = i_bus16 ?
    i_mem_addr[21:1] :
    i_mem_addr[22:2];
  // byte pin 0 is unused by 16-bit parts and is held low
  wire logic [1:0] map_byte = i_bus16 ?
    {i_mem_addr[0], 1'b0} :
    i_mem_addr[1:0];

  // latch enables override the address on pins 12 and 11 in nand mode;
  // they stay driven between cycles so the flash never sees a float
  logic [14:0] dedic_out_nxt;
  logic [14:0] dedic_oe_n_nxt;
  always_comb begin
    dedic_out_nxt  = map_addr[14:0];
    dedic_oe_n_nxt = {15{~i_addr_oe}};
    if (i_nand_mode) begin
      dedic_out_nxt[emapm_pkg::CLE_PIN]  = i_nand_cle;
      dedic_out_nxt[emapm_pkg::ALE_PIN]  = i_nand_ale;
      dedic_oe_n_nxt[emapm_pkg::CLE_PIN] = 1'b0;
      dedic_oe_n_nxt[emapm_pkg::ALE_PIN] = 1'b0;
    end
  end

  // dedicated pins ignore the share register entirely
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      dedic_out_r  <= 15'h0000;
      dedic_oe_n_r <= 15'h7fff;
      byte_sel_r   <= 2'h0;
    end else begin
      dedic_out_r  <= dedic_out_nxt;
      dedic_oe_n_r <= dedic_oe_n_nxt;
      byte_sel_r   <= map_byte;
    end
  end

  // one cell per shared pin
  genvar k;
  generate
    for (k = 0; k < 6; k = k + 1) begin : g_share
      emapm_share_cell u_cell (
        .i_clk_sys    (i_clk_sys),
        .i_rst_n      (i_rst_n),
        .i_mode_io    (pin_share_select_reg_r[k]),
        .i_mem_bit    (map_addr[15 + k]),
        .i_mem_oe     (i_addr_oe),
        .i_io_out     (i_general_io_line_out[k]),
        .i_io_dir_out (i_general_io_line_dir[k]),
        .i_pad_in     (i_ext_addr_pins[15 + k]),
        .o_pad_out    (shared_out[k]),
        .o_pad_oe_n   (shared_oe_n[k]),
        .o_io_in      (o_general_io_line_in[k])
      );
    end
  endgenerate

  // pad assembly
  assign o_ext_addr_pins      = {shared_out, dedic_out_r};
  assign o_ext_addr_pins_oe_n = {shared_oe_n, dedic_oe_n_r};
  assign o_ext_byte_sel_addr  = byte_sel_r;

  // checks on the pin mapping, one cycle after the request
  addr8_map_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_addr_oe && !i_bus16 && !i_nand_mode)
      |=> (o_ext_addr_pins[14:0] == $past(i_mem_addr[16:2]))
          && (o_ext_addr_pins_oe_n[14:0] == 15'h0000))
    else $error("8-bit address not on pins 14..0");

  byte8_map_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    !i_bus16 |=> o_ext_byte_sel_addr == $past(i_mem_addr[1:0]))
    else $error("8-bit byte pins wrong");

  addr16_map_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_bus16 && !i_nand_mode)
      |=> o_ext_addr_pins[14:0] == $past(i_mem_addr[15:1]))
    else $error("16-bit address not on pins 14..0");

  byte16_map_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    i_bus16 |=> (o_ext_byte_sel_addr[1] == $past(i_mem_addr[0]))
                && !o_ext_byte_sel_addr[0])
    else $error("16-bit halfword bit not on byte pin 1");

  share_emif_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (!pin_share_select_reg_r[5] && i_addr_oe && !i_bus16)
      |=> (o_ext_addr_pins[20] == $past(i_mem_addr[22]))
          && !o_ext_addr_pins_oe_n[20])
    else $error("pin 20 not carrying address in memory mode");

  share_write_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    wr_share |=> pin_share_select_reg_r == $past(i_reg_wdata[5:0]))
    else $error("share select write lost");

  cle_drive_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    i_nand_mode |=> (o_ext_addr_pins[12] == $past(i_nand_cle))
                    && !o_ext_addr_pins_oe_n[12])
    else $error("command latch enable not on pin 12");

  ale_drive_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    i_nand_mode |=> (o_ext_addr_pins[11] == $past(i_nand_ale))
                    && !o_ext_addr_pins_oe_n[11])
    else $error("address latch enable not on pin 11");

  pulldown_ctl_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    wr_pull ##1 !wr_pull
      |-> o_internal_pulldown_en == ~$past(i_reg_wdata[5:0]))
    else $error("pulldown enable does not follow inhibit write");

  dedic_only_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (!i_addr_oe && !i_nand_mode)
      |=> o_ext_addr_pins_oe_n[14:0] == 15'h7fff)
    else $error("dedicated pin driven without the memory interface");

  gpio_route_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    pin_share_select_reg_r[0]
      |=> (o_ext_addr_pins[15] == $past(i_general_io_line_out[0]))
          && (o_ext_addr_pins_oe_n[15]
              == !$past(i_general_io_line_dir[0])))
    else $error("pin 15 in i/o mode not driven by i/o logic");

  read_back_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    rd_pull |=> o_reg_rdata == {10'h000, $past(pull_inhibit_reg_r)})
    else $error("pull inhibit readback wrong");

  // register port: one-cycle read data, control bits held between writes
  read_share_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    rd_share
      |=> o_reg_rdata == {10'h000, $past(pin_share_select_reg_r)})
    else $error("share select readback wrong");

  read_pins_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    rd_pins
      |=> o_reg_rdata == {10'h000, $past(i_ext_addr_pins[20:15])})
    else $error("pin status readback wrong");

  read_mode_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    rd_mode |=> o_reg_rdata == {13'h0, $past(mode_stat)})
    else $error("mode status readback wrong");

  rdata_idle_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    !i_reg_rd |=> o_reg_rdata == 16'h0000)
    else $error("read data outlived its cycle");

  share_hold_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    !wr_share |=> $stable(pin_share_select_reg_r))
    else $error("share select changed without a write");

  pull_write_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    wr_pull |=> pull_inhibit_reg_r == $past(i_reg_wdata[5:0]))
    else $error("pull inhibit write lost");

  pull_hold_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    !wr_pull |=> $stable(pull_inhibit_reg_r))
    else $error("pull inhibit changed without a write");

  // no disable here, so the cleared state itself is what gets checked
  reset_state_a: assert property (
    @(posedge i_clk_sys)
    !i_rst_n |=> (o_ext_addr_pins_oe_n == 21'h1fffff)
                 && (o_internal_pulldown_en == 6'h3f)
                 && (o_reg_rdata == 16'h0000)
                 && (o_ext_byte_sel_addr == 2'h0))
    else $error("outputs not at their reset state");

  // shared pins: address in memory mode, i/o input gated off in memory mode
  addr8_high_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (pin_share_select_reg_r == 6'h00 && !i_bus16)
      |=> o_ext_addr_pins[20:15] == $past(i_mem_addr[22:17]))
    else $error("8-bit upper address not on pins 20..15");

  addr16_high_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (pin_share_select_reg_r == 6'h00 && i_bus16)
      |=> o_ext_addr_pins[20:15] == $past(i_mem_addr[21:16]))
    else $error("16-bit upper address not on pins 20..15");

  mem_pin_oe_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    !pin_share_select_reg_r[5]
      |=> o_ext_addr_pins_oe_n[20] == !$past(i_addr_oe))
    else $error("pin 20 enable does not follow the controller");

  io_in_gate_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    o_general_io_line_in
      == (pin_share_select_reg_r & i_ext_addr_pins[20:15]))
    else $error("i/o input seen on a pin in memory mode");

  dedic_drive_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_addr_oe && !i_nand_mode)
      |=> o_ext_addr_pins_oe_n[14:0] == 15'h0000)
    else $error("dedicated pin not driven for the controller");

  nand_idle_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_nand_mode && !i_addr_oe)
      |=> (o_ext_addr_pins_oe_n[12:11] == 2'h0)
          && (o_ext_addr_pins_oe_n[14:13] == 2'h3)
          && (o_ext_addr_pins_oe_n[10:0] == 11'h7ff))
    else $error("nand idle pins wrong");

endmodule // emapm_pin_mux

// >>> pkg/emapm_pkg.sv
package emapm_pkg;

  // pin geometry of the external address port
  localparam int unsigned ADDR_PINS   = 21;
  localparam int unsigned MEM_ADDR_W  = 23;
  localparam int unsigned BYTE_SEL_W  = 2;
  localparam int unsigned SHARED_PINS = 6;
  localparam int unsigned SHARE_LO    = 15;
  localparam int unsigned DEDIC_PINS  = 15;
  localparam int unsigned CLE_PIN     = 12;
  localparam int unsigned ALE_PIN     = 11;

  // register port geometry
  localparam int unsigned REG_AW = 4;
  localparam int unsigned REG_DW = 16;

  // register offsets
  localparam logic [3:0] OFS_SHARE_SEL = 4'h0;
  localparam logic [3:0] OFS_PULL_INH  = 4'h1;
  localparam logic [3:0] OFS_PIN_STAT  = 4'h2;
  localparam logic [3:0] OFS_MODE_STAT = 4'h3;

  // field positions: bit k of the share and pull fields is pin 15+k
  localparam int unsigned SHARE_SEL_LSB  = 0;
  localparam int unsigned PULL_INH_LSB   = 0;
  localparam int unsigned PIN_STAT_LSB   = 0;
  localparam int unsigned STAT_BUS16_BIT = 0;
  localparam int unsigned STAT_NAND_BIT  = 1;
  localparam int unsigned STAT_AOE_BIT   = 2;

  // reset values: all shared pins on the memory side, pulldowns enabled
  localparam logic [5:0] RST_SHARE_SEL = 6'h00;
  localparam logic [5:0] RST_PULL_INH  = 6'h00;

endpackage

// >>> hdl/emapm_share_cell.sv
`timescale 1ns/1ps
// one shared upper address pin: memory address bit or general i/o line
module emapm_share_cell (
  input  wire logic i_clk_sys,
  input  wire logic i_rst_n,
  input  wire logic i_mode_io,
  input  wire logic i_mem_bit,
  input  wire logic i_mem_oe,
  input  wire logic i_io_out,
  input  wire logic i_io_dir_out,
  input  wire logic i_pad_in,
  output logic      o_pad_out,
  output logic      o_pad_oe_n,
  output logic      o_io_in
);

  // selection; in i/o mode the memory bit never reaches the pad
  wire logic pad_out_nxt  = i_mode_io ? i_io_out : i_mem_bit;
  wire logic pad_oe_n_nxt = i_mode_io ? ~i_io_dir_out : ~i_mem_oe;

  // the i/o side only sees the pad while it owns it
  assign o_io_in = i_mode_io & i_pad_in;

  // pad drivers registered so the pin never glitches on a mode change
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_pad_out  <= 1'b0;
      o_pad_oe_n <= 1'b1;
    end else begin
      o_pad_out  <= pad_out_nxt;
      o_pad_oe_n <= pad_oe_n_nxt;
    end
  end

endmodule // emapm_share_cell

// >>> dv/emapm_mem_model.sv
`timescale 1ns/1ps
// far-side memory pads: resolves each address line from every driver
module emapm_mem_model (
  input  wire logic        i_clk_sys,
  input  wire logic [20:0] i_pins,
  input  wire logic [20:0] i_oe_n,
  input  wire logic [5:0]  i_pd_en,
  input  wire logic [20:0] i_drv_en,
  input  wire logic [20:0] i_drv_val,
  output logic      [20:0] o_pad
);
  logic [20:0] flip_r = 21'h0;
  // a floating line wanders, so a stale level never passes for valid
  always @(posedge i_clk_sys) flip_r <= ~flip_r;
  // device first, then far side, then pulldown on shared pins
  always_comb begin
    for (int k = 0; k < 21; k++) begin
      if (!i_oe_n[k]) o_pad[k] = i_pins[k];
      else if (i_drv_en[k]) o_pad[k] = i_drv_val[k];
      else if (k >= 15 && i_pd_en[k-15]) o_pad[k] = 1'b0;
      else o_pad[k] = flip_r[k];
    end
  end
endmodule // emapm_mem_model

// >>> dv/test_ext_mem_addr_pin_mux.sv
`timescale 1ns/1ps
module test_ext_mem_addr_pin_mux;
  typedef struct packed {
    logic        b16;
    logic [22:0] addr;
    logic [20:0] pins;
    logic [1:0]  bsel;
  } emapm_row_s;
  logic        i_clk_sys = 1'b0;
  logic        i_rst_n = 1'b0;
  logic [22:0] i_mem_addr = 23'h0;
  logic        i_addr_oe = 1'b0;
  logic        i_bus16 = 1'b0;
  logic        i_nand_mode = 1'b0;
  logic        i_nand_cle = 1'b0;
  logic        i_nand_ale = 1'b0;
  logic [5:0]  i_general_io_line_out = 6'h00;
  logic [5:0]  i_general_io_line_dir = 6'h00;
  logic [3:0]  i_reg_addr = 4'h0;
  logic [15:0] i_reg_wdata = 16'h0000;
  logic        i_reg_wr = 1'b0;
  logic        i_reg_rd = 1'b0;
  logic [20:0] drv_en = 21'h0;
  logic [20:0] drv_val = 21'h0;
  logic [20:0] i_ext_addr_pins;
  logic [5:0]  o_general_io_line_in;
  logic [15:0] o_reg_rdata;
  logic [20:0] o_ext_addr_pins;
  logic [20:0] o_ext_addr_pins_oe_n;
  logic [1:0]  o_ext_byte_sel_addr;
  logic [5:0]  o_internal_pulldown_en;
  logic [15:0] rd;
  int          failures = 0;
  int          tests_run = 0;
  int          cycles = 0;
  emapm_row_s  rows [8] = '{
    '{1'b0, 23'h2aaaaa, 21'h0aaaaa, 2'h2},
    '{1'b0, 23'h555555, 21'h155555, 2'h1},
    '{1'b0, 23'h7fffff, 21'h1fffff, 2'h3},
    '{1'b0, 23'h000000, 21'h000000, 2'h0},
    '{1'b1, 23'h2aaaaa, 21'h155555, 2'h0},
    '{1'b1, 23'h555555, 21'h0aaaaa, 2'h2},
    '{1'b1, 23'h7fffff, 21'h1fffff, 2'h2},
    '{1'b1, 23'h000000, 21'h000000, 2'h0}};

  emapm_pin_mux u_dut (.i_clk_sys, .i_rst_n, .i_mem_addr, .i_addr_oe,
    .i_bus16, .i_nand_mode, .i_nand_cle, .i_nand_ale,
    .i_general_io_line_out, .i_general_io_line_dir, .o_general_io_line_in,
    .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata,
    .i_ext_addr_pins, .o_ext_addr_pins, .o_ext_addr_pins_oe_n,
    .o_ext_byte_sel_addr, .o_internal_pulldown_en);
  emapm_mem_model u_mem (.i_clk_sys, .i_pins(o_ext_addr_pins),
    .i_oe_n(o_ext_addr_pins_oe_n), .i_pd_en(o_internal_pulldown_en),
    .i_drv_en(drv_en), .i_drv_val(drv_val), .o_pad(i_ext_addr_pins));

  // 40 MHz system clock
  initial begin
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk_sys);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge i_clk_sys);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_reg_rd <= 1'b0;
    #1 d = o_reg_rdata;
  endtask
  task automatic tick2;
    repeat (2) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic complete_run;
    $display("checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // hang guard: the whole sequence needs well under 200 cycles
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      $display("unexpected at %0t: timeout", $time);
      complete_run();
    end
  end

  initial begin
    repeat (10) @(posedge i_clk_sys);
    #1;
    chk(o_ext_addr_pins_oe_n, 21'h1fffff);
    chk(o_internal_pulldown_en, 6'h3f);
    chk(o_general_io_line_in, 6'h00);
    @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      @(posedge i_clk_sys);
      i_bus16 <= rows[i].b16;
      i_mem_addr <= rows[i].addr;
      i_addr_oe <= 1'b1;
      tick2();
      chk(o_ext_addr_pins, rows[i].pins);
      chk(o_ext_byte_sel_addr, rows[i].bsel);
      chk(o_ext_addr_pins_oe_n, 21'h0);
    end
    $display("address table done");
    // pin 15 to i/o, others still memory; all high address bits
    reg_wr(emapm_pkg::OFS_SHARE_SEL, 16'h0001);
    i_general_io_line_out <= 6'h3e;
    i_general_io_line_dir <= 6'h01;
    i_mem_addr <= 23'h7fffff;
    tick2();
    chk(o_ext_addr_pins[20:15], 6'h3e);
    chk(o_ext_addr_pins_oe_n[20:15], 6'h00);
    reg_wr(emapm_pkg::OFS_SHARE_SEL, 16'h003f);
    drv_en <= 21'h1f0000;
    drv_val <= 21'h0b0000;
    tick2();
    chk(o_ext_addr_pins_oe_n[20:15], 6'h3e);
    chk(o_ext_addr_pins[14:0], 15'h7fff);
    chk(o_ext_addr_pins_oe_n[14:0], 15'h0);
    chk(o_general_io_line_in, 6'h16);
    reg_rd(emapm_pkg::OFS_PIN_STAT, rd);
    chk(rd, 16'h0016);
    // status offsets ignore writes; share select must survive this
    reg_wr(emapm_pkg::OFS_PIN_STAT, 16'h0000);
    reg_rd(emapm_pkg::OFS_SHARE_SEL, rd);
    chk(rd, 16'h003f);
    reg_rd(4'hf, rd);
    chk(rd, 16'h0000);
    $display("sharing test done");
    reg_wr(emapm_pkg::OFS_PULL_INH, 16'h0015);
    tick2();
    chk(o_internal_pulldown_en, 6'h2a);
    reg_rd(emapm_pkg::OFS_PULL_INH, rd);
    chk(rd, 16'h0015);
    $display("pulldown test done");
    @(posedge i_clk_sys);
    i_nand_mode <= 1'b1;
    i_addr_oe <= 1'b0;
    i_nand_cle <= 1'b1;
    tick2();
    chk(o_ext_addr_pins[12:11], 2'h2);
    chk(o_ext_addr_pins_oe_n[12:11], 2'h0);
    @(posedge i_clk_sys);
    i_nand_cle <= 1'b0;
    i_nand_ale <= 1'b1;
    tick2();
    chk(o_ext_addr_pins[12:11], 2'h1);
    reg_rd(emapm_pkg::OFS_MODE_STAT, rd);
    chk(rd, 16'h0003);
    @(posedge i_clk_sys);
    #1 chk(o_reg_rdata, 16'h0000);
    $display("latch enable test done");
    // mid-run reset with the controller idle, so no stale request leaks
    @(posedge i_clk_sys);
    i_rst_n <= 1'b0;
    i_nand_mode <= 1'b0;
    i_nand_ale <= 1'b0;
    i_bus16 <= 1'b0;
    i_mem_addr <= 23'h0;
    repeat (2) @(posedge i_clk_sys);
    #1;
    chk(o_ext_addr_pins_oe_n, 21'h1fffff);
    chk(o_internal_pulldown_en, 6'h3f);
    chk(o_ext_byte_sel_addr, 2'h0);
    @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    reg_rd(emapm_pkg::OFS_SHARE_SEL, rd);
    chk(rd, 16'h0000);
    $display("mid-run reset test done");
    complete_run();
  end
endmodule // test_ext_mem_addr_pin_mux
